// ---- rtl/diag_status_register_bank.sv ----
// Diagnostic flags, commands, identification and gyro data registers on the serial port
`timescale 1ns/1ps

// Functional notes
// - Bit 7: sync lock lost, scaled mode only
// - Bit 6: flash CRC differs from original
// - Bit 5: a sensor failed self test
// - Bit 4 and halt on low supply
// - Bit 3: clock count not multiple of 16
// - Bit 2: last flash update failed
// - Bit 1: any data path overrun
// - Flags sticky; a read of the flag register clears all
// - Persisting fault sets flag again
// - Command bits 2,3,4 start tests/update
// - Gyro axis as 32-bit word pair
// - Read-only 32-bit flash write count
// - Bias period register, reset 0x070A
// - Fixed read-only device number
module diag_status_register_bank import diag_pkg::*; #(
   parameter int SUPPLY_GOOD_CYCLES_P = SUPPLY_GOOD_CYCLES,
   parameter logic [15:0] DEVICE_NUMBER_P = 16'h1234, // Arbitrary value
   parameter logic [15:0] FIRMWARE_REVISION_P = 16'h0100, // Arbitrary value
   parameter logic [15:0] FIRMWARE_DAY_MONTH_P = 16'h0101, // Arbitrary value
   parameter logic [15:0] FIRMWARE_YEAR_P = 16'h0000, // Arbitrary value
   parameter logic [15:0] UNIT_SERIAL_P = 16'h0001 // Arbitrary value
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   input wire gyro_rates_t gyro_rates_i,
   input wire logic sync_lock_fail_i,
   input wire logic supply_low_i,
   input wire logic overrun_i,
   input wire test_results_t results_i,
   output commands_t commands_o,
   output flash_image_t flash_image_o,
   output logic data_run_o,
   output logic reinit_o
);

   localparam int CNT_W = $clog2(SUPPLY_GOOD_CYCLES_P + 1);
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SUPPLY_GOOD_CYCLES_P - 1);

   if (SUPPLY_GOOD_CYCLES_P < 1) begin : g_bad_settle
      $error("diag_status_register_bank: SUPPLY_GOOD_CYCLES_P must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Serial front end
   logic [15:0] rx_word;
   logic word_valid, frame_end, frame_misaligned;
   logic [15:0] tx_word, next_tx_word;

   spi_frame_port #(
      .FRAME_BITS_P(FRAME_BITS)
   ) u_port (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .sclk_i(sclk_i),
      .cs_n_i(cs_n_i),
      .mosi_i(mosi_i),
      .tx_word_i(tx_word),
      .miso_o(miso_o),
      .word_o(rx_word),
      .word_valid_o(word_valid),
      .frame_end_o(frame_end),
      .frame_misaligned_o(frame_misaligned)
   );

   // Word decode: odd address selects the high byte of the pair
   logic [6:0] reg_addr;
   logic [7:0] wr_byte;
   logic is_read, write_lo, write_hi;

   always_comb begin
      reg_addr = {rx_word[SPI_ADDR_MSB:SPI_ADDR_LSB+1], 1'b0};
      wr_byte = rx_word[SPI_DATA_MSB:0];
      is_read = word_valid && !rx_word[SPI_WRITE_BIT];
      write_lo = word_valid && rx_word[SPI_WRITE_BIT] && !rx_word[SPI_ADDR_LSB];
      write_hi = word_valid && rx_word[SPI_WRITE_BIT] && rx_word[SPI_ADDR_LSB];
   end

   function automatic logic [15:0] byte_write(input logic [15:0] old, input logic [7:0] d,
                                              input logic hi);
      byte_write = hi ? {d, old[7:0]} : {old[15:8], d};
   endfunction : byte_write

   ////////////////////////////////////////////////////////////////////////////////
   // Flash-backed configuration registers
   flash_image_t cfg, next_cfg;

   always_comb begin
      next_cfg = cfg;
      if (write_lo || write_hi) begin
         case (reg_addr)
            MISC_IO_CONTROL_ADDR: next_cfg.misc_io_control =
               byte_write(cfg.misc_io_control, wr_byte, write_hi);
            BIAS_PERIOD_ADDR: next_cfg.bias_estimation_period =
               byte_write(cfg.bias_estimation_period, wr_byte, write_hi);
            SCRATCH_ONE_ADDR: next_cfg.scratch_one =
               byte_write(cfg.scratch_one, wr_byte, write_hi);
            SCRATCH_TWO_ADDR: next_cfg.scratch_two =
               byte_write(cfg.scratch_two, wr_byte, write_hi);
            SCRATCH_THREE_ADDR: next_cfg.scratch_three =
               byte_write(cfg.scratch_three, wr_byte, write_hi);
            default: next_cfg = cfg;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cfg.misc_io_control <= MISC_IO_CONTROL_RESET;
         cfg.bias_estimation_period <= BIAS_PERIOD_RESET;
         cfg.scratch_one <= SCRATCH_RESET;
         cfg.scratch_two <= SCRATCH_RESET;
         cfg.scratch_three <= SCRATCH_RESET;
      end else begin
         cfg <= next_cfg;
      end
   end

   // Flash engine stores this image on an update
   assign flash_image_o = cfg;

   ////////////////////////////////////////////////////////////////////////////////
   // Global command pulses; only the low byte carries command bits
   commands_t next_commands;

   always_comb begin
      next_commands = '0;
      if (write_lo && reg_addr == GLOBAL_COMMAND_ADDR) begin
         next_commands.self_test = wr_byte[CMD_SELF_TEST_BIT];
         next_commands.flash_update = wr_byte[CMD_FLASH_UPDATE_BIT];
         next_commands.flash_test = wr_byte[CMD_FLASH_TEST_BIT];
         next_commands.soft_reset = wr_byte[CMD_SOFT_RESET_BIT];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         commands_o <= '0;
      end else begin
         commands_o <= next_commands;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Supply supervisor; supply comparator is asynchronous, so synchronise it
   logic supply_meta, supply_low_s;
   power_state_t pwr_state, next_pwr_state;
   logic [CNT_W-1:0] settle_cnt, next_settle_cnt;
   logic next_reinit;

   always_comb begin
      next_pwr_state = pwr_state;
      next_settle_cnt = settle_cnt;
      next_reinit = 1'b0;
      case (pwr_state)
         PWR_RUN: begin
            if (supply_low_s) begin
               next_pwr_state = PWR_STANDBY;
            end
         end
         PWR_STANDBY: begin
            next_settle_cnt = '0;
            if (!supply_low_s) begin
               next_pwr_state = PWR_SETTLE;
            end
         end
         PWR_SETTLE: begin
            // Any dip restarts the full settle time
            if (supply_low_s) begin
               next_pwr_state = PWR_STANDBY;
            end else if (settle_cnt == SETTLE_LAST) begin
               next_pwr_state = PWR_RUN;
               next_reinit = 1'b1;
            end else begin
               next_settle_cnt = settle_cnt + CNT_W'(1);
            end
         end
         default: next_pwr_state = PWR_STANDBY;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         supply_meta <= 1'b0;
         supply_low_s <= 1'b0;
         pwr_state <= PWR_RUN;
         settle_cnt <= '0;
         reinit_o <= 1'b0;
      end else begin
         supply_meta <= supply_low_i;
         supply_low_s <= supply_meta;
         pwr_state <= next_pwr_state;
         settle_cnt <= next_settle_cnt;
         reinit_o <= next_reinit;
      end
   end

   // Data processing stops outside the run state
   assign data_run_o = (pwr_state == PWR_RUN);

   ////////////////////////////////////////////////////////////////////////////////
   // Test outcome latches keep a failing result alive across clearing reads
   logic crc_bad, self_test_bad, update_bad;
   logic next_crc_bad, next_self_test_bad, next_update_bad;
   logic [31:0] flash_writes, next_flash_writes;

   always_comb begin
      next_crc_bad = results_i.crc_test_done ? results_i.crc_mismatch : crc_bad;
      next_self_test_bad = results_i.self_test_done ? results_i.self_test_fail : self_test_bad;
      next_update_bad = results_i.update_done ? !results_i.update_ok : update_bad;
      next_flash_writes = flash_writes;
      if (results_i.update_done) begin
         next_flash_writes = flash_writes + 32'h0000_0001;
      end
      if (commands_o.soft_reset) begin
         next_crc_bad = results_i.crc_test_done && results_i.crc_mismatch;
         next_self_test_bad = results_i.self_test_done && results_i.self_test_fail;
         next_update_bad = results_i.update_done && !results_i.update_ok;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         crc_bad <= 1'b0;
         self_test_bad <= 1'b0;
         update_bad <= 1'b0;
         flash_writes <= 32'h0000_0000;
      end else begin
         crc_bad <= next_crc_bad;
         self_test_bad <= next_self_test_bad;
         update_bad <= next_update_bad;
         flash_writes <= next_flash_writes;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky error flags; a live fault beats the clear in the same cycle
   logic [15:0] error_flags, next_error_flags, fault_now;
   logic flags_clear;

   always_comb begin
      fault_now = 16'h0000;
      fault_now[FLAG_CLOCK_SYNC] = sync_lock_fail_i &&
         (cfg.misc_io_control[SYNC_MODE_MSB:SYNC_MODE_LSB] == SYNC_MODE_SCALED);
      fault_now[FLAG_FLASH_TEST] = next_crc_bad;
      fault_now[FLAG_SELF_TEST] = next_self_test_bad;
      fault_now[FLAG_STANDBY] = supply_low_s;
      fault_now[FLAG_FRAMING] = frame_end && frame_misaligned;
      fault_now[FLAG_FLASH_UPDATE] = next_update_bad;
      fault_now[FLAG_OVERRUN] = overrun_i;
      flags_clear = (is_read && reg_addr == ERROR_FLAGS_ADDR) || commands_o.soft_reset;
      next_error_flags = ((flags_clear ? 16'h0000 : error_flags) | fault_now) &
                         ERROR_FLAGS_USED;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         error_flags <= ERROR_FLAGS_RESET;
      end else begin
         error_flags <= next_error_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux; answer goes out in the following word
   logic [15:0] read_value;

   always_comb begin
      case (reg_addr)
         ERROR_FLAGS_ADDR: read_value = error_flags;
         X_RATE_LOW_ADDR: read_value = gyro_rates_i.x[15:0];
         X_RATE_HIGH_ADDR: read_value = gyro_rates_i.x[31:16];
         Y_RATE_LOW_ADDR: read_value = gyro_rates_i.y[15:0];
         Y_RATE_HIGH_ADDR: read_value = gyro_rates_i.y[31:16];
         Z_RATE_LOW_ADDR: read_value = gyro_rates_i.z[15:0];
         Z_RATE_HIGH_ADDR: read_value = gyro_rates_i.z[31:16];
         MISC_IO_CONTROL_ADDR: read_value = cfg.misc_io_control;
         BIAS_PERIOD_ADDR: read_value = cfg.bias_estimation_period;
         FIRMWARE_REVISION_ADDR: read_value = FIRMWARE_REVISION_P;
         FIRMWARE_DAY_MONTH_ADDR: read_value = FIRMWARE_DAY_MONTH_P;
         FIRMWARE_YEAR_ADDR: read_value = FIRMWARE_YEAR_P;
         DEVICE_NUMBER_ADDR: read_value = DEVICE_NUMBER_P;
         UNIT_SERIAL_ADDR: read_value = UNIT_SERIAL_P;
         SCRATCH_ONE_ADDR: read_value = cfg.scratch_one;
         SCRATCH_TWO_ADDR: read_value = cfg.scratch_two;
         SCRATCH_THREE_ADDR: read_value = cfg.scratch_three;
         FLASH_WRITES_LO_ADDR: read_value = flash_writes[15:0];
         FLASH_WRITES_HI_ADDR: read_value = flash_writes[31:16];
         default: read_value = 16'h0000;
      endcase
   end

   // Writes answer zero so no stale data leaks into the next word
   always_comb begin
      next_tx_word = tx_word;
      if (is_read) begin
         next_tx_word = read_value;
      end else if (word_valid) begin
         next_tx_word = 16'h0000;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         tx_word <= 16'h0000;
      end else begin
         tx_word <= next_tx_word;
      end
   end

endmodule : diag_status_register_bank

// ---- rtl/diag_pkg.sv ----
// Shared constants, field layouts and carrier types for the diagnostic register bank
package diag_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial word layout
   localparam int FRAME_BITS = 16;
   localparam int SPI_WRITE_BIT = 15;
   localparam int SPI_ADDR_MSB = 14;
   localparam int SPI_ADDR_LSB = 8;
   localparam int SPI_DATA_MSB = 7;

   ////////////////////////////////////////////////////////////////////////////////
   // Byte addresses of the 16-bit registers (even address of each pair)
   localparam logic [6:0] ERROR_FLAGS_ADDR = 7'h02;
   localparam logic [6:0] X_RATE_LOW_ADDR = 7'h04;
   localparam logic [6:0] X_RATE_HIGH_ADDR = 7'h06;
   localparam logic [6:0] Y_RATE_LOW_ADDR = 7'h08;
   localparam logic [6:0] Y_RATE_HIGH_ADDR = 7'h0A;
   localparam logic [6:0] Z_RATE_LOW_ADDR = 7'h0C;
   localparam logic [6:0] Z_RATE_HIGH_ADDR = 7'h0E;
   localparam logic [6:0] MISC_IO_CONTROL_ADDR = 7'h60;
   localparam logic [6:0] BIAS_PERIOD_ADDR = 7'h66;
   localparam logic [6:0] GLOBAL_COMMAND_ADDR = 7'h68;
   localparam logic [6:0] FIRMWARE_REVISION_ADDR = 7'h6C;
   localparam logic [6:0] FIRMWARE_DAY_MONTH_ADDR = 7'h6E;
   localparam logic [6:0] FIRMWARE_YEAR_ADDR = 7'h70;
   localparam logic [6:0] DEVICE_NUMBER_ADDR = 7'h72;
   localparam logic [6:0] UNIT_SERIAL_ADDR = 7'h74;
   localparam logic [6:0] SCRATCH_ONE_ADDR = 7'h76;
   localparam logic [6:0] SCRATCH_TWO_ADDR = 7'h78;
   localparam logic [6:0] SCRATCH_THREE_ADDR = 7'h7A;
   localparam logic [6:0] FLASH_WRITES_LO_ADDR = 7'h7C;
   localparam logic [6:0] FLASH_WRITES_HI_ADDR = 7'h7E;

   ////////////////////////////////////////////////////////////////////////////////
   // Error flag positions
   localparam int FLAG_CLOCK_SYNC = 7;
   localparam int FLAG_FLASH_TEST = 6;
   localparam int FLAG_SELF_TEST = 5;
   localparam int FLAG_STANDBY = 4;
   localparam int FLAG_FRAMING = 3;
   localparam int FLAG_FLASH_UPDATE = 2;
   localparam int FLAG_OVERRUN = 1;
   localparam logic [15:0] ERROR_FLAGS_USED = 16'h00FE;

   // Global command bit positions
   localparam int CMD_SELF_TEST_BIT = 2;
   localparam int CMD_FLASH_UPDATE_BIT = 3;
   localparam int CMD_FLASH_TEST_BIT = 4;
   localparam int CMD_SOFT_RESET_BIT = 7;

   // Sync mode field of misc_io_control
   localparam int SYNC_MODE_LSB = 2;
   localparam int SYNC_MODE_MSB = 4;
   localparam logic [2:0] SYNC_MODE_SCALED = 3'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] ERROR_FLAGS_RESET = 16'h0000;
   localparam logic [15:0] MISC_IO_CONTROL_RESET = 16'h00C1;
   localparam logic [15:0] BIAS_PERIOD_RESET = 16'h070A;
   localparam logic [15:0] SCRATCH_RESET = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int SUPPLY_GOOD_MS = 250;
   localparam int SUPPLY_GOOD_CYCLES = SUPPLY_GOOD_MS * (CLK_HZ / 1000);

   ////////////////////////////////////////////////////////////////////////////////
   // Carrier types
   typedef struct packed {
      logic signed [31:0] x;
      logic signed [31:0] y;
      logic signed [31:0] z;
   } gyro_rates_t;

   typedef struct packed {
      logic self_test_done;
      logic self_test_fail;
      logic crc_test_done;
      logic crc_mismatch;
      logic update_done;
      logic update_ok;
   } test_results_t;

   typedef struct packed {
      logic self_test;
      logic flash_update;
      logic flash_test;
      logic soft_reset;
   } commands_t;

   typedef struct packed {
      logic [15:0] misc_io_control;
      logic [15:0] bias_estimation_period;
      logic [15:0] scratch_one;
      logic [15:0] scratch_two;
      logic [15:0] scratch_three;
   } flash_image_t;

   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_STANDBY,
      PWR_SETTLE
   } power_state_t;

endpackage : diag_pkg

// ---- rtl/spi_frame_port.sv ----
// Serial port front end: pin synchronisers, 16-bit word shifter, frame length check
`timescale 1ns/1ps
module spi_frame_port import diag_pkg::*; #(
   parameter int FRAME_BITS_P = FRAME_BITS
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   input wire logic [FRAME_BITS_P-1:0] tx_word_i,
   output logic miso_o,
   output logic [FRAME_BITS_P-1:0] word_o,
   output logic word_valid_o,
   output logic frame_end_o,
   output logic frame_misaligned_o
);

   localparam int CW = $clog2(FRAME_BITS_P);
   localparam logic [CW-1:0] LAST_BIT = CW'(FRAME_BITS_P - 1);

   if (FRAME_BITS_P < 2) begin : g_bad_width
      $error("spi_frame_port: FRAME_BITS_P must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers; bit 0 clock, bit 1 select, bit 2 data
   logic [2:0] pin_meta, pin_sync, pin_last;
   logic [2:0] next_meta, next_sync, next_last;

   always_comb begin
      next_meta = {mosi_i, cs_n_i, sclk_i};
      next_sync = pin_meta;
      next_last = pin_sync;
   end

   // Idle levels: clock high, select high
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pin_meta <= 3'h3;
         pin_sync <= 3'h3;
         pin_last <= 3'h3;
      end else begin
         pin_meta <= next_meta;
         pin_sync <= next_sync;
         pin_last <= next_last;
      end
   end

   logic sclk_rise, sclk_fall, in_frame, cs_rise;

   always_comb begin
      sclk_rise = pin_sync[0] && !pin_last[0];
      sclk_fall = !pin_sync[0] && pin_last[0];
      in_frame = !pin_sync[1];
      cs_rise = pin_sync[1] && !pin_last[1];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shifters; sample on rising clock, drive on falling clock
   logic [FRAME_BITS_P-1:0] rx_sh, tx_sh, next_rx_sh, next_tx_sh, next_word;
   logic [CW-1:0] bit_cnt, next_bit_cnt;
   logic next_valid, next_end, next_misaligned;

   always_comb begin
      next_rx_sh = rx_sh;
      next_tx_sh = tx_sh;
      next_word = word_o;
      next_bit_cnt = bit_cnt;
      next_valid = 1'b0;
      next_end = 1'b0;
      next_misaligned = 1'b0;
      if (in_frame && sclk_rise) begin
         next_rx_sh = {rx_sh[FRAME_BITS_P-2:0], pin_sync[2]};
         if (bit_cnt == LAST_BIT) begin
            next_bit_cnt = '0;
            next_word = {rx_sh[FRAME_BITS_P-2:0], pin_sync[2]};
            next_valid = 1'b1;
         end else begin
            next_bit_cnt = bit_cnt + CW'(1);
         end
      end
      // Leading edge of each word reloads the answer
      if (in_frame && sclk_fall) begin
         if (bit_cnt == '0) begin
            next_tx_sh = tx_word_i;
         end else begin
            next_tx_sh = {tx_sh[FRAME_BITS_P-2:0], 1'b0};
         end
      end
      // Frame length judged once, when select goes high
      if (cs_rise) begin
         next_end = 1'b1;
         next_misaligned = (bit_cnt != '0);
         next_bit_cnt = '0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rx_sh <= '0;
         tx_sh <= '0;
         word_o <= '0;
         bit_cnt <= '0;
         word_valid_o <= 1'b0;
         frame_end_o <= 1'b0;
         frame_misaligned_o <= 1'b0;
      end else begin
         rx_sh <= next_rx_sh;
         tx_sh <= next_tx_sh;
         word_o <= next_word;
         bit_cnt <= next_bit_cnt;
         word_valid_o <= next_valid;
         frame_end_o <= next_end;
         frame_misaligned_o <= next_misaligned;
      end
   end

   assign miso_o = tx_sh[FRAME_BITS_P-1];

endmodule : spi_frame_port

// ---- verif/diag_bank_monitor.sv ----
// Port-level assertions for the diagnostic register bank
`timescale 1ns/1ps
module diag_bank_monitor import diag_pkg::*; #(
   parameter int SUPPLY_GOOD_CYCLES_P = SUPPLY_GOOD_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic supply_low_i,
   input wire commands_t commands_o,
   input wire logic data_run_o,
   input wire logic reinit_o
);
   int good_cnt, next_good_cnt;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   // Run of good supply cycles, saturating so a long run cannot wrap
   always_comb begin
      next_good_cnt = supply_low_i ? 0 : good_cnt + int'(good_cnt < SUPPLY_GOOD_CYCLES_P + 8);
   end
   always_ff @(posedge core_clk_i) begin
      good_cnt <= rst_i ? 0 : next_good_cnt;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Supervisor; sync stages allow a few cycles of lag
   standby_halt_a: assert property (supply_low_i [*6] |-> !data_run_o)
      else $error("data still running on low supply");
   standby_hold_a: assert property (supply_low_i [*3] |=> !data_run_o)
      else $error("left standby while supply low");
   settle_time_a: assert property ($rose(data_run_o) |->
      $past(good_cnt, 3) >= SUPPLY_GOOD_CYCLES_P)
      else $error("resumed before settle time");
   run_reinit_a: assert property ($rose(data_run_o) |-> reinit_o || $past(reinit_o))
      else $error("resumed without reinit");
   reinit_pulse_a: assert property (reinit_o |=> !reinit_o && data_run_o)
      else $error("reinit not a single pulse into run");
   reinit_good_a: assert property (reinit_o |-> !$past(supply_low_i, 3))
      else $error("reinit while supply low");
   // Commands come from serial writes only
   cmd_pulse_a: assert property (|commands_o |=> commands_o == '0)
      else $error("command longer than one cycle");
   cmd_in_frame_a: assert property (|commands_o |-> !$past(cs_n_i, 4))
      else $error("command without a frame");
   cover property (reinit_o);
   cover property (!data_run_o);
   cover property (commands_o.flash_test);
endmodule : diag_bank_monitor
bind diag_status_register_bank diag_bank_monitor #(.SUPPLY_GOOD_CYCLES_P(SUPPLY_GOOD_CYCLES_P))
   diag_bank_monitor_inst (.core_clk_i, .rst_i, .cs_n_i, .supply_low_i, .commands_o,
   .data_run_o, .reinit_o);

// ---- verif/spi_host_model.sv ----
// Host serial master model driving mode 3 frames
`timescale 1ns/1ps
module spi_host_model (
   input wire logic core_clk_i,
   input wire logic miso_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o
);
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // n bits MSB first; n other than 16 breaks framing on purpose
   task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge core_clk_i) cs_n_o <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      for (int i = 15; i > 15 - n; i--) begin
         @(posedge core_clk_i) sclk_o <= 1'b0;
         mosi_o <= tx[i];
         repeat (8) @(posedge core_clk_i); // Slow edges so the pin syncs keep up
         sclk_o <= 1'b1;
         rx = {rx[14:0], miso_i};
         repeat (8) @(posedge core_clk_i);
      end
      cs_n_o <= 1'b1;
      mosi_o <= ~mosi_o; // Released line shows no stale value
      repeat (6) @(posedge core_clk_i);
   endtask : frame
endmodule : spi_host_model

// ---- verif/diag_status_register_bank_bench.sv ----
// Self-checking bench for the diagnostic register bank
`timescale 1ns/1ps
module diag_status_register_bank_bench import diag_pkg::*;;
   typedef struct packed {logic wr; logic [6:0] addr; logic [15:0] data;} row_t;
   localparam int SETTLE = 20;
   localparam logic [15:0] DEV_NUM = 16'h5A5A; // Arbitrary value
   localparam row_t ROWS [12] = '{'{1'b0, ERROR_FLAGS_ADDR, 16'h0000},
      '{1'b0, BIAS_PERIOD_ADDR, 16'h070A}, '{1'b0, DEVICE_NUMBER_ADDR, DEV_NUM},
      '{1'b1, BIAS_PERIOD_ADDR, 16'hC3A5}, '{1'b0, BIAS_PERIOD_ADDR, 16'hC3A5},
      '{1'b1, FLASH_WRITES_HI_ADDR, 16'hFFFF}, '{1'b0, FLASH_WRITES_HI_ADDR, 16'h0000},
      '{1'b0, 7'h6A, 16'h0000}, '{1'b0, X_RATE_LOW_ADDR, 16'h0001},
      '{1'b0, X_RATE_HIGH_ADDR, 16'hB1E0}, '{1'b0, Z_RATE_HIGH_ADDR, 16'hFFFF},
      '{1'b0, Z_RATE_LOW_ADDR, 16'hFFFE}};
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sclk, cs_n, mosi, miso, sync_fail, supply_low, overrun, data_run;
   test_results_t results = '0;
   commands_t commands;
   flash_image_t image;
   logic [15:0] cmd_cnt [4] = '{default: 16'h0000};
   logic [15:0] junk;
   int mismatches = 0;
   int samples_checked = 0;
   always #5 core_clk_i = ~core_clk_i;
   // Command pulses counted so a missing or doubled one shows
   always @(posedge core_clk_i) begin
      for (int i = 0; i < 4; i++) cmd_cnt[i] <= cmd_cnt[i] + 16'(commands[i] === 1'b1);
   end
   spi_host_model spi_host_model_inst (.core_clk_i, .miso_i(miso), .sclk_o(sclk),
      .cs_n_o(cs_n), .mosi_o(mosi));
   diag_status_register_bank #(.SUPPLY_GOOD_CYCLES_P(SETTLE), .DEVICE_NUMBER_P(DEV_NUM))
      diag_status_register_bank_inst (.core_clk_i, .rst_i, .sclk_i(sclk), .cs_n_i(cs_n),
      .mosi_i(mosi), .miso_o(miso), .gyro_rates_i({32'hB1E0_0001, 32'h4E20_0000,
      32'hFFFF_FFFE}), .sync_lock_fail_i(sync_fail), .supply_low_i(supply_low),
      .overrun_i(overrun), .results_i(results), .commands_o(commands),
      .flash_image_o(image), .data_run_o(data_run), .reinit_o());
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Read answers in the following word
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] d;
      spi_host_model_inst.frame({1'b0, a, 8'h00}, 16, d);
      spi_host_model_inst.frame(16'h0000, 16, d);
      chk($sformatf("reg %h", a), d, exp);
   endtask : rd
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      spi_host_model_inst.frame({1'b1, a, d[7:0]}, 16, junk);
      spi_host_model_inst.frame({1'b1, a | 7'h01, d[15:8]}, 16, junk);
   endtask : wr
   task automatic pulse(input test_results_t v);
      @(posedge core_clk_i) results <= v;
      @(posedge core_clk_i) results <= '0;
   endtask : pulse
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (80000) @(posedge core_clk_i);
      mismatches++;
      close_out();
   end
   initial begin
      {sync_fail, supply_low, overrun} = 3'h0;
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      foreach (ROWS[i]) begin
         if (ROWS[i].wr) wr(ROWS[i].addr, ROWS[i].data);
         else rd(ROWS[i].addr, ROWS[i].data);
      end
      // Sticky overrun, cleared by read, then by soft reset
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk_i) overrun <= 1'b1;
         @(posedge core_clk_i) overrun <= 1'b0;
         if (k == 1) wr(GLOBAL_COMMAND_ADDR, 16'h0080);
         rd(ERROR_FLAGS_ADDR, k ? 16'h0000 : 16'h0002);
      end
      rd(ERROR_FLAGS_ADDR, 16'h0000);
      // Low supply: halt, flag comes back after each read
      @(posedge core_clk_i) supply_low <= 1'b1;
      rd(ERROR_FLAGS_ADDR, 16'h0010);
      rd(ERROR_FLAGS_ADDR, 16'h0010);
      chk("run", {15'h0, data_run}, 16'h0000);
      @(posedge core_clk_i) supply_low <= 1'b0;
      repeat (SETTLE + 10) @(posedge core_clk_i);
      chk("run", {15'h0, data_run}, 16'h0001);
      rd(ERROR_FLAGS_ADDR, 16'h0010);
      // Clock sync flag only in scaled mode
      @(posedge core_clk_i) sync_fail <= 1'b1;
      rd(ERROR_FLAGS_ADDR, 16'h0000);
      wr(MISC_IO_CONTROL_ADDR, 16'h00C9);
      chk("misc", image.misc_io_control, 16'h00C9);
      rd(ERROR_FLAGS_ADDR, 16'h0080);
      @(posedge core_clk_i) sync_fail <= 1'b0;
      rd(ERROR_FLAGS_ADDR, 16'h0080);
      // Failed test results latch until a passing run
      for (int k = 0; k < 3; k++) begin
         pulse(k == 0 ? 6'h30 : k == 1 ? 6'h0C : 6'h02);
         rd(ERROR_FLAGS_ADDR, 16'h0020 << k >> (k == 2 ? 5 : 0));
         rd(ERROR_FLAGS_ADDR, 16'h0020 << k >> (k == 2 ? 5 : 0));
         pulse(k == 0 ? 6'h20 : k == 1 ? 6'h08 : 6'h03);
         rd(ERROR_FLAGS_ADDR, 16'h0020 << k >> (k == 2 ? 5 : 0));
         rd(ERROR_FLAGS_ADDR, 16'h0000);
      end
      rd(FLASH_WRITES_LO_ADDR, 16'h0002);
      // Short frame of 15 clocks
      spi_host_model_inst.frame(16'hFFFF, 15, junk);
      rd(ERROR_FLAGS_ADDR, 16'h0008);
      // Each command bit gives one pulse on its own output
      for (int k = 0; k < 3; k++) begin
         wr(GLOBAL_COMMAND_ADDR, 16'h0004 << k);
         chk("command", cmd_cnt[3 - k], 16'h0001);
      end
      chk("soft reset", cmd_cnt[0], 16'h0001);
      close_out();
   end
endmodule : diag_status_register_bank_bench
